// file: dv/flash_supply_model.sv
`default_nettype none
module flash_supply_model (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic save_req,
   input  wire logic restore_req,
   input  wire logic ctx_ok,
   input  wire logic slow,
   output logic      save_done,
   output logic      restore_done,
   output logic      app_valid,
   output logic      context_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] dly;
   logic       tog;
   // validity lines carry nothing useful outside restore_done
   assign app_valid     = restore_done ? 1'b1 : tog;
   assign context_valid = restore_done ? ctx_ok : ~tog;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dly          <= 3'h0;
         tog          <= 1'b0;
         save_done    <= 1'b0;
         restore_done <= 1'b0;
      end else begin
         tog          <= ~tog;
         save_done    <= 1'b0;
         restore_done <= 1'b0;
         if ((save_req || restore_req) && !save_done && !restore_done) begin
            dly <= dly + 3'h1;
            if (dly == (slow ? 3'h5 : 3'h0)) begin
               dly          <= 3'h0;
               save_done    <= save_req;
               restore_done <= restore_req && !save_req;
            end
         end else begin
            dly <= 3'h0;
         end
      end
   end
endmodule
`default_nettype wire

// file: dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DCN = 8;
   localparam int ACN = 40;
   localparam logic [31:0] CT = run_stop_pkg::CTRL_OFFSET;
   localparam logic [31:0] CM = run_stop_pkg::CMD_OFFSET;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = run_stop_pkg::HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, sv_done, rs_done, a_ok, c_ok;
   logic        rs_in = 1'b0, rs_err = 1'b0, mp_in = 1'b0, mp_err = 1'b0;
   logic        sup_ok = 1'b1, btn = 1'b0, cpu_err = 1'b0, ctx_ok = 1'b1, slow = 1'b0;
   logic        run, exe, mprot, sreq, rreq, fb, ainit, mwi, uli, warm, cflag;
   int          err_count = 0, check_count = 0, cyc = 0;
   int          n_app = 0, n_mw = 0, n_unl = 0, n_warm = 0;
   always #5 hclk = ~hclk;
   run_stop_power_restart_control #(.OUTAGE_AC_CYCLES(ACN), .OUTAGE_DC_CYCLES(DCN)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .run_stop_in(rs_in), .run_stop_err(rs_err),
      .mem_protect_in(mp_in), .mem_protect_err(mp_err), .supply_ok(sup_ok), .reset_button(btn),
      .cpu_error(cpu_err), .save_done(sv_done), .restore_done(rs_done), .app_valid(a_ok),
      .context_valid(c_ok), .run_mode(run), .exec_enable(exe), .mem_protect(mprot),
      .save_req(sreq), .restore_req(rreq), .outputs_fallback(fb), .app_init(ainit),
      .mw_init(mwi), .unlocated_init(uli), .warm_restart(warm), .cold_start_flag_bit(cflag));
   flash_supply_model far (
      .hclk(hclk), .hresetn(hresetn), .save_req(sreq), .restore_req(rreq), .ctx_ok(ctx_ok),
      .slow(slow), .save_done(sv_done), .restore_done(rs_done), .app_valid(a_ok),
      .context_valid(c_ok));
   task report_and_stop;
      if (err_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // pulse outputs are counted so that scenarios can compare deltas
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      n_app <= n_app + int'(ainit === 1'b1);
      n_mw <= n_mw + int'(mwi === 1'b1);
      n_unl <= n_unl + int'(uli === 1'b1);
      n_warm <= n_warm + int'(warm === 1'b1);
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task rdc(input string w, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(w, x, e);
   endtask
   task t_regs;
      rdc("ctrl", CT, 32'h0);
      rdc("status", run_stop_pkg::STATUS_OFFSET, 32'h0);
      hsize <= 3'h0;
      wr(CT, 32'h3f);
      hsize <= run_stop_pkg::HSIZE_WORD;
      rdc("byte write ignored", CT, 32'h0);
      wr(CT, 32'h3f);
      rdc("ctrl rw", CT, 32'h3f);
      rdc("cmd", CM, 32'h0);
      rdc("unmapped", 32'h0000_000c, 32'h0);
      chk("hresp", hresp, 32'h0);
      chk("hreadyout", hreadyout, 32'h1);
      wr(CT, 32'h0);
   endtask
   task t_remote;
      wr(CM, 32'h1);
      wt(2);
      chk("run", run, 1);
      chk("exec", exe, 1);
      wr(CM, 32'h2);
      wt(2);
      chk("run", run, 0);
      wr(CM, 32'h1);
      wr(CM, 32'h3);
      wt(2);
      chk("run", run, 0);
      wr(CT, 32'h1);
      wr(CM, 32'h1);
      wt(2);
      chk("run", run, 0);
      rs_in <= 1'b1;
      wt(3);
      chk("run", run, 1);
      wr(CM, 32'h2);
      wt(2);
      chk("run", run, 0);
      rs_in <= 1'b0;
      wt(2);
      rs_in <= 1'b1;
      wt(3);
      wr(CT, 32'h3);
      wr(CM, 32'h2);
      wt(2);
      chk("run", run, 1);
      rs_in <= 1'b0;
      wt(3);
      chk("run", run, 0);
      rs_in <= 1'b1;
      wt(3);
      rs_err <= 1'b1;
      wt(3);
      chk("run", run, 0);
      rs_err <= 1'b0;
      rs_in <= 1'b0;
      wr(CT, 32'h8);
      mp_in <= 1'b1;
      wt(3);
      chk("protect", mprot, 1);
      mp_in <= 1'b0;
      wt(3);
      chk("protect", mprot, 0);
      mp_err <= 1'b1;
      wt(3);
      chk("protect", mprot, 1);
      mp_err <= 1'b0;
      wr(CT, 32'h0);
   endtask
   task t_short(input logic [31:0] ctrl, input int n);
      wr(CT, ctrl);
      wr(CM, 32'h1);
      sup_ok <= 1'b0;
      wt(n);
      sup_ok <= 1'b1;
      wt(6);
      chk("save_req", sreq, 0);
      chk("exec", exe, 1);
   endtask
   task t_long(input logic [31:0] ctrl, input int th, input logic ok);
      int k;
      int a0;
      int w0;
      wr(CT, ctrl);
      wr(CM, 32'h1);
      ctx_ok <= ok;
      a0 = n_app;
      w0 = n_warm;
      k = 0;
      sup_ok <= 1'b0;
      while (sreq !== 1'b1 && k < 100) begin
         @(posedge hclk);
         k++;
      end
      chk("qualify time", 32'(k >= th && k <= th + 4), 1);
      chk("exec", exe, 0);
      chk("early fallback", fb, 0);
      k = 0;
      while (fb !== 1'b1 && k < 100) begin
         @(posedge hclk);
         k++;
      end
      chk("save_req", sreq, 0);
      chk("fallback", fb, 1);
      sup_ok <= 1'b1;
      k = 0;
      while (fb !== 1'b0 && k < 100) begin
         @(posedge hclk);
         k++;
      end
      wt(2);
      chk("restore_req", rreq, 0);
      chk("warm", 32'(n_warm - w0), 32'(ok));
      chk("app init", 32'(n_app - a0), 32'(!ok));
      chk("run", run, 32'(ok));
      chk("flag", cflag, 32'(!ok));
      ctx_ok <= 1'b1;
   endtask
   task t_causes;
      int u0;
      int m0;
      for (int au = 0; au < 2; au++) begin
         for (int c = 0; c < 4; c++) begin
            wr(CT, au != 0 ? 32'h4 : 32'h0);
            wr(CM, au != 0 ? 32'h2 : 32'h1);
            wr(CM, 32'h20);
            u0 = n_unl;
            m0 = n_mw;
            cpu_err <= (c == 3);
            if (c < 2) begin
               wr(CM, c == 0 ? 32'h8 : 32'h10);
            end else begin
               btn <= 1'b1;
               wt(1);
               btn <= 1'b0;
            end
            wt(3);
            chk("cause run", run, 32'(au != 0 && c != 3));
            chk("cause flag", cflag, 1);
            chk("unlocated", 32'(n_unl - u0), 32'(c == 0));
            chk("words", 32'(n_mw - m0), 32'(c > 1));
            cpu_err <= 1'b0;
         end
      end
   endtask
   task t_init;
      int a0;
      wr(CT, 32'h0);
      wr(CM, 32'h1);
      wr(CM, 32'h20);
      wt(2);
      a0 = n_app;
      wr(CM, 32'h4);
      wt(3);
      chk("init pulse", 32'(n_app - a0), 1);
      chk("init run", run, 1);
      chk("init flag", cflag, 0);
   endtask
   task t_reset;
      wr(CT, 32'h20);
      hresetn <= 1'b0;
      wt(2);
      hresetn <= 1'b1;
      wt(1);
      chk("reset run", run, 32'h0);
      chk("reset ready", hreadyout, 32'h1);
      rdc("reset ctrl", CT, 32'h0);
   endtask
   initial begin
      wt(3);
      hresetn <= 1'b1;
      wt(1);
      t_regs();
      t_remote();
      t_short(32'h10, DCN - 1);
      t_short(32'h0, ACN - 1);
      t_long(32'h10, DCN, 1'b1);
      slow <= 1'b1;
      t_long(32'h0, ACN, 1'b0);
      t_causes();
      t_init();
      t_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire

// file: src/run_stop_pkg.sv
`default_nettype none
package run_stop_pkg;
   // register byte addresses
   localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
   localparam logic [31:0] CMD_OFFSET    = 32'h0000_0004;
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0008;
   localparam logic [5:0]  CTRL_RESET    = 6'h00;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;

   // control field positions
   localparam int CTRL_RS_EN_BIT    = 0;
   localparam int CTRL_ONLY_BIT     = 1;
   localparam int CTRL_AUTO_RUN_BIT = 2;
   localparam int CTRL_MP_EN_BIT    = 3;
   localparam int CTRL_DC_BIT       = 4;

   // command field positions, write one to act
   localparam int CMD_RUN_BIT      = 0;
   localparam int CMD_STOP_BIT     = 1;
   localparam int CMD_INIT_BIT     = 2;
   localparam int CMD_DL_BIT       = 3;
   localparam int CMD_MISMATCH_BIT = 4;
   localparam int CMD_FLAG_CLR_BIT = 5;

   // supply filtering times
   localparam int FILTER_AC_MS  = 10;
   localparam int FILTER_DC_MS  = 1;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS     = 1000000;
   localparam int FILTER_AC_CYCLES = FILTER_AC_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int FILTER_DC_CYCLES = FILTER_DC_MS * NS_PER_MS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      PH_RUNNING,
      PH_SAVE,
      PH_DOWN,
      PH_RESTORE
   } phase_t;
endpackage
`default_nettype wire

// file: src/run_stop_power_restart_control.sv
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`default_nettype none
module run_stop_power_restart_control #(
   parameter int unsigned OUTAGE_AC_CYCLES = run_stop_pkg::FILTER_AC_CYCLES,
   parameter int unsigned OUTAGE_DC_CYCLES = run_stop_pkg::FILTER_DC_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        run_stop_in,
   input  wire logic        run_stop_err,
   input  wire logic        mem_protect_in,
   input  wire logic        mem_protect_err,
   input  wire logic        supply_ok,
   input  wire logic        reset_button,
   input  wire logic        cpu_error,
   input  wire logic        save_done,
   input  wire logic        restore_done,
   input  wire logic        app_valid,
   input  wire logic        context_valid,
   output logic             run_mode,
   output logic             exec_enable,
   output logic             mem_protect,
   output logic             save_req,
   output logic             restore_req,
   output logic             outputs_fallback,
   output logic             app_init,
   output logic             mw_init,
   output logic             unlocated_init,
   output logic             warm_restart,
   output logic             cold_start_flag_bit
);
   typedef struct packed {
      run_stop_pkg::phase_t phase;
      logic [5:0]           ctrl;
      logic                 wr_pend;
      logic [31:0]          addr_q;
      logic [31:0]          rdata;
      logic                 ready;
      logic                 resp;
      logic                 run;
      logic                 exec;
      logic                 mprot;
      logic                 hold;
      logic                 save_req;
      logic                 restore_req;
      logic                 fallback;
      logic                 app_init;
      logic                 mw_init;
      logic                 unl_init;
      logic                 warm;
      logic                 cold_flag;
   } ctl_t;

   localparam ctl_t ST_RESET = '{
      phase:   run_stop_pkg::PH_RUNNING,
      ctrl:    run_stop_pkg::CTRL_RESET,
      ready:   1'b1,
      default: '0
   };

   ctl_t       st_reg;
   ctl_t       st_next;
   logic       outage_long;
   logic       acc;
   logic [5:0] cmd;
   logic       rs_en;
   logic       only;
   logic       auto_run;
   logic       mp_en;
   logic       remote_run;
   logic       remote_stop;
   logic       in_run;
   logic       stop_req;
   logic       run_req;
   logic       lost_ctx;
   logic       cold_any;
   logic       cold_run;
   logic       init_req;

   supply_outage_filter #(
      .AC_CYCLES (OUTAGE_AC_CYCLES),
      .DC_CYCLES (OUTAGE_DC_CYCLES)
   ) u_filter (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .supply_ok   (supply_ok),
      .dc_supply   (st_reg.ctrl[run_stop_pkg::CTRL_DC_BIT]),
      .outage_long (outage_long)
   );

   always_comb begin
      st_next          = st_reg;
      st_next.app_init = 1'b0;
      st_next.mw_init  = 1'b0;
      st_next.unl_init = 1'b0;
      st_next.warm     = 1'b0;
      st_next.ready    = 1'b1;
      st_next.resp     = 1'b0;

      // bus slave: zero wait states, word accesses only
      acc = hsel && hready && htrans[1] && (hsize == run_stop_pkg::HSIZE_WORD);
      st_next.wr_pend = acc && hwrite;
      if (acc) begin
         st_next.addr_q = haddr;
      end
      if (acc && !hwrite) begin
         case (haddr)
            run_stop_pkg::CTRL_OFFSET: begin
               st_next.rdata = {26'h0, st_reg.ctrl};
            end
            run_stop_pkg::STATUS_OFFSET: begin
               st_next.rdata = {21'h0, st_reg.phase, 1'b0, st_reg.hold, st_reg.cold_flag,
                                st_reg.fallback, outage_long, st_reg.mprot, st_reg.exec, st_reg.run};
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end
      if (st_reg.wr_pend && st_reg.addr_q == run_stop_pkg::CTRL_OFFSET) begin
         st_next.ctrl = hwdata[5:0];
      end
      cmd = '0;
      if (st_reg.wr_pend && st_reg.addr_q == run_stop_pkg::CMD_OFFSET) begin
         cmd = hwdata[5:0];
      end

      rs_en    = st_reg.ctrl[run_stop_pkg::CTRL_RS_EN_BIT];
      only     = st_reg.ctrl[run_stop_pkg::CTRL_ONLY_BIT];
      auto_run = st_reg.ctrl[run_stop_pkg::CTRL_AUTO_RUN_BIT];
      mp_en    = st_reg.ctrl[run_stop_pkg::CTRL_MP_EN_BIT];

      // remote access gating
      remote_stop = cmd[run_stop_pkg::CMD_STOP_BIT] && !(rs_en && only);
      remote_run  = cmd[run_stop_pkg::CMD_RUN_BIT] && !rs_en;
      stop_req    = remote_stop || (rs_en && (!run_stop_in || run_stop_err));

      // remote stop holds off the input until it drops to 0
      if (remote_stop) begin
         st_next.hold = 1'b1;
      end else if (!run_stop_in) begin
         st_next.hold = 1'b0;
      end
      in_run  = rs_en && run_stop_in && !run_stop_err && !st_reg.hold;
      run_req = remote_run || in_run;

      // power outage sequence
      lost_ctx = 1'b0;
      case (st_reg.phase)
         run_stop_pkg::PH_RUNNING: begin
            if (outage_long) begin
               st_next.phase    = run_stop_pkg::PH_SAVE;
               st_next.save_req = 1'b1;
            end
         end
         run_stop_pkg::PH_SAVE: begin
            if (save_done) begin
               st_next.save_req = 1'b0;
               st_next.fallback = 1'b1;
               st_next.phase    = run_stop_pkg::PH_DOWN;
            end
         end
         run_stop_pkg::PH_DOWN: begin
            if (!outage_long) begin
               st_next.restore_req = 1'b1;
               st_next.phase       = run_stop_pkg::PH_RESTORE;
            end
         end
         run_stop_pkg::PH_RESTORE: begin
            if (restore_done) begin
               st_next.restore_req = 1'b0;
               st_next.fallback    = 1'b0;
               st_next.phase       = run_stop_pkg::PH_RUNNING;
               if (app_valid && context_valid) begin
                  st_next.warm = 1'b1;
               end else begin
                  lost_ctx = 1'b1;
               end
            end
         end
         default: begin
            st_next.phase = run_stop_pkg::PH_RUNNING;
         end
      endcase

      // reset button aborts any sequence and reloads memory words
      if (reset_button) begin
         st_next.phase       = run_stop_pkg::PH_RUNNING;
         st_next.save_req    = 1'b0;
         st_next.restore_req = 1'b0;
         st_next.fallback    = 1'b0;
         st_next.mw_init     = 1'b1;
      end
      if (cmd[run_stop_pkg::CMD_DL_BIT]) begin
         st_next.unl_init = 1'b1;
      end

      cold_any = reset_button || lost_ctx || cmd[run_stop_pkg::CMD_DL_BIT]
                 || cmd[run_stop_pkg::CMD_MISMATCH_BIT];
      cold_run = auto_run && !(reset_button && cpu_error);
      init_req = cmd[run_stop_pkg::CMD_INIT_BIT]
                 || (cmd[run_stop_pkg::CMD_FLAG_CLR_BIT] && st_reg.cold_flag);

      if (cold_any || init_req) begin
         st_next.app_init = 1'b1;
      end
      // a cold start in the same cycle wins over software clearing the flag
      if (cold_any) begin
         st_next.cold_flag = 1'b1;
      end else if (cmd[run_stop_pkg::CMD_FLAG_CLR_BIT]) begin
         st_next.cold_flag = 1'b0;
      end

      if (cold_any) begin
         st_next.run = cold_run;
      end else if (run_req) begin
         st_next.run = 1'b1;
      end
      if (stop_req) begin
         st_next.run = 1'b0;
      end
      st_next.exec  = st_next.run && (st_next.phase == run_stop_pkg::PH_RUNNING) && !outage_long;
      st_next.mprot = mp_en && (mem_protect_in || mem_protect_err);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hrdata              = st_reg.rdata;
   assign hreadyout           = st_reg.ready;
   assign hresp               = st_reg.resp;
   assign run_mode            = st_reg.run;
   assign exec_enable         = st_reg.exec;
   assign mem_protect         = st_reg.mprot;
   assign save_req            = st_reg.save_req;
   assign restore_req         = st_reg.restore_req;
   assign outputs_fallback    = st_reg.fallback;
   assign app_init            = st_reg.app_init;
   assign mw_init             = st_reg.mw_init;
   assign unlocated_init      = st_reg.unl_init;
   assign warm_restart        = st_reg.warm;
   assign cold_start_flag_bit = st_reg.cold_flag;

   property p_input_run;
      @(posedge hclk) disable iff (!hresetn) in_run && !stop_req && !cold_any |=> run_mode;
   endproperty
   a_input_run: assert property (p_input_run) else $error("input 1 did not run");

   property p_stop_wins;
      @(posedge hclk) disable iff (!hresetn) stop_req |=> !run_mode;
   endproperty
   a_stop_wins: assert property (p_stop_wins) else $error("stop request did not stop");

   property p_err_stop;
      @(posedge hclk) disable iff (!hresetn) rs_en && run_stop_err |=> !run_mode && !exec_enable;
   endproperty
   a_err_stop: assert property (p_err_stop) else $error("input error did not stop");

   property p_remote_refused;
      @(posedge hclk) disable iff (!hresetn)
         rs_en && only && cmd[run_stop_pkg::CMD_STOP_BIT] && in_run && !cold_any |=> run_mode;
   endproperty
   a_remote_refused: assert property (p_remote_refused) else $error("refused remote stop acted");

   property p_mprot_off;
      @(posedge hclk) disable iff (!hresetn)
         mp_en && !mem_protect_in && !mem_protect_err |=> !mem_protect;
   endproperty
   a_mprot_off: assert property (p_mprot_off) else $error("memory protected with input 0");

   property p_mprot_err;
      @(posedge hclk) disable iff (!hresetn) mp_en && mem_protect_err |=> mem_protect;
   endproperty
   a_mprot_err: assert property (p_mprot_err) else $error("input error left memory open");

   property p_halt;
      @(posedge hclk) disable iff (!hresetn) outage_long |=> !exec_enable;
   endproperty
   a_halt: assert property (p_halt) else $error("program ran during outage");

   property p_fallback;
      @(posedge hclk) disable iff (!hresetn)
         $rose(outputs_fallback) |-> $past(save_req) && $past(save_done);
   endproperty
   a_fallback: assert property (p_fallback) else $error("fallback before context save");

   property p_warm;
      @(posedge hclk) disable iff (!hresetn)
         st_reg.phase == run_stop_pkg::PH_RESTORE && restore_done && app_valid && context_valid
         && !reset_button && cmd == 6'h00 |=> warm_restart && !app_init;
   endproperty
   a_warm: assert property (p_warm) else $error("valid context did not warm restart");

   property p_cpu_err;
      @(posedge hclk) disable iff (!hresetn)
         reset_button && cpu_error |=> !run_mode && cold_start_flag_bit && mw_init;
   endproperty
   a_cpu_err: assert property (p_cpu_err) else $error("reset after error did not stop");

   property p_download;
      @(posedge hclk) disable iff (!hresetn)
         cmd[run_stop_pkg::CMD_DL_BIT] |=> app_init && unlocated_init && cold_start_flag_bit;
   endproperty
   a_download: assert property (p_download) else $error("download did not cold start");

   property p_init_keeps;
      @(posedge hclk) disable iff (!hresetn)
         init_req && !cold_any && !stop_req && !run_req |=> app_init && (run_mode == $past(run_mode));
   endproperty
   a_init_keeps: assert property (p_init_keeps) else $error("init request changed run state");

   property p_button_words;
      @(posedge hclk) disable iff (!hresetn) reset_button |=> mw_init && app_init && cold_start_flag_bit;
   endproperty
   a_button_words: assert property (p_button_words) else $error("reset button did not reload words");
endmodule
`default_nettype wire

// file: src/supply_outage_filter.sv
`default_nettype none
module supply_outage_filter #(
   parameter int unsigned AC_CYCLES = run_stop_pkg::FILTER_AC_CYCLES,
   parameter int unsigned DC_CYCLES = run_stop_pkg::FILTER_DC_CYCLES
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic supply_ok,
   input  wire logic dc_supply,
   output logic      outage_long
);
   typedef struct packed {
      logic [31:0] cnt;
      logic        long_q;
   } filt_t;

   filt_t       f_reg;
   filt_t       f_next;
   logic [31:0] thr;

   always_comb begin
      f_next = f_reg;
      thr = dc_supply ? 32'(DC_CYCLES) : 32'(AC_CYCLES);
      if (supply_ok) begin
         f_next.cnt    = '0;
         f_next.long_q = 1'b0;
      end else if (f_reg.cnt >= thr - 32'd1) begin
         f_next.long_q = 1'b1;
      end else begin
         f_next.cnt = f_reg.cnt + 32'd1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         f_reg <= '0;
      end else begin
         f_reg <= f_next;
      end
   end

   assign outage_long = f_reg.long_q;

   property p_short_no_effect;
      @(posedge hclk) disable iff (!hresetn) supply_ok |=> !outage_long;
   endproperty
   a_short_no_effect: assert property (p_short_no_effect) else $error("short outage was qualified");

   property p_threshold;
      @(posedge hclk) disable iff (!hresetn)
         !supply_ok && !outage_long && (f_reg.cnt == thr - 32'd1) |=> outage_long;
   endproperty
   a_threshold: assert property (p_threshold) else $error("outage not qualified at threshold");
endmodule
`default_nettype wire
